// ===== rtl/hrwc_pkg.sv
// Constants, register map and carrier types of the resonance wave control block
package hrwc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_NS      = 100;
   localparam longint     PER_LSB_PS  = 1333320;   // Period LSB, 1333.32 ns
   localparam int          TICK_CYC    = int'(PER_LSB_PS / (CLK_NS * 1000));
   localparam logic [3:0]  TICK_LAST   = 4'(TICK_CYC - 1);
   localparam longint     PS_PER_S    = 64'd1000000000000;
   localparam longint     FREQ_MIN_HZ = 50;
   localparam longint     FREQ_MAX_HZ = 300;
   localparam logic [14:0] PER_MAX     = 15'(PS_PER_S / (FREQ_MIN_HZ * PER_LSB_PS));
   localparam logic [14:0] PER_MIN     = 15'(PS_PER_S / (FREQ_MAX_HZ * PER_LSB_PS));
   localparam logic [14:0] PER_SAT     = 15'h7FFF;
   localparam logic [2:0]  BRAKE_MIN_HP = 3'h3;    // Brake allowed only after more than this many half-periods
   localparam int          GAIN_SHIFT  = 8;

   // ----------------------------------------------------------------
   // Shape points
   // ----------------------------------------------------------------
   localparam logic [8:0]  PT_ZERO     = 9'h000;
   localparam logic [8:0]  PT_PEAK     = 9'h100;   // 100 % of peak current

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  A_CTRL   = 8'h00;
   localparam logic [7:0]  A_GAIN   = 8'h04;
   localparam logic [7:0]  A_LIMIT  = 8'h08;
   localparam logic [7:0]  A_DPER   = 8'h0C;
   localparam logic [7:0]  A_SHAPE  = 8'h10;
   localparam logic [7:0]  A_V2I    = 8'h14;
   localparam logic [7:0]  A_PNOW   = 8'h18;
   localparam logic [7:0]  A_PAVG   = 8'h1C;
   localparam logic [7:0]  A_IMP    = 8'h20;
   localparam logic [7:0]  A_STAT   = 8'h24;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic motion_sense_en;
      logic brake_en;
      logic shape_gen_select;
      logic amplitude_loop_en;
      logic resistance_cal_off;
      logic factor_hold;
      logic range_check_block;
      logic prop_gain_autoscale_en;
      logic resonance_follow_en;
   } hrwc_ctrl_t;

   typedef struct packed {
      logic [15:0] freq_integ_gain;
      logic [15:0] freq_prop_gain;
   } hrwc_gain_t;

   typedef struct packed {
      logic [7:0] brake_threshold;
      logic [7:0] track_min_backemf;
      logic [7:0] initial_lock_threshold;
   } hrwc_limit_t;

   typedef struct packed {
      logic [4:0] peak_current;
      logic [7:0] shape_point3_scale;
      logic [7:0] shape_point2_scale;
      logic [7:0] shape_point1_scale;
   } hrwc_shape_t;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam hrwc_ctrl_t  CTRL_RST  = 9'h181;
   localparam hrwc_gain_t  GAIN_RST  = 32'h0040_0080;
   localparam hrwc_limit_t LIMIT_RST = 24'h30_10_08;
   localparam logic [14:0] DPER_RST  = 15'h0EA6;
   localparam hrwc_shape_t SHAPE_RST = 29'h1FEC_B461;
   localparam logic [15:0] V2I_RST   = 16'h0100;

endpackage : hrwc_pkg

// ===== rtl/hrwc_top.sv
// Resonance tracking, braking, impedance and custom wave drive control
`timescale 1ns/10ps
`default_nettype none
module hrwc_top
   import hrwc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_zero_cross,
   input  wire logic [7:0]  i_backemf,
   input  wire logic [9:0]  i_imp_meas,
   input  wire logic        i_play_active,
   input  wire logic        i_play_start,
   input  wire logic        i_stop_req,
   input  wire logic [7:0]  i_amplitude,
   input  wire logic        i_frame_per_vld,
   input  wire logic [14:0] i_frame_per,
   output logic      [7:0]  o_drive_level,
   output logic             o_drive_polarity,
   output logic             o_brake,
   output logic             o_fault,
   output logic             o_track_on,
   output logic      [14:0] o_drive_period
);

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   hrwc_ctrl_t         ctrl_q;
   hrwc_gain_t         gain_q;
   hrwc_limit_t        lim_q;
   hrwc_shape_t        shape_q;
   logic [14:0]        dper_q;
   logic [15:0]        v2i_q;
   logic [9:0]         imp_q;
   logic               fault_q;
   logic               lock_q;
   logic               trk_q;
   logic [14:0]        track_q;
   logic signed [21:0] integ_q;
   logic [14:0]        per_now_q;
   logic [14:0]        per_avg_q;
   logic [14:0]        hist_q [4];
   logic [14:0]        meas_q;
   logic [3:0]         tick_q;
   logic               tick;
   logic [2:0]         zc_sync_q;
   logic               zc_evt;
   logic [14:0]        act_per_q;
   logic [14:0]        hp_cnt_q;
   logic               bnd;
   logic               pol_q;
   logic [2:0]         hp_num_q;
   logic               stop_pend_q;
   logic               brake_q;
   logic               imp_pend_q;
   logic [7:0]         amp_q;
   logic [14:0]        step_q;
   logic [2:0]         pt_q;
   logic [8:0]         pt_val;
   logic [16:0]        lvl_prod;
   logic [31:0]        rdata;
   logic [31:0]        wmerged;
   logic               wr;
   logic               range_err;
   logic               trk_ok;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   always_comb begin
      case (i_wb_adr)
         A_CTRL:  rdata = 32'(ctrl_q);
         A_GAIN:  rdata = gain_q;
         A_LIMIT: rdata = 32'(lim_q);
         A_DPER:  rdata = {16'h0000, dper_q[14:7], 1'b0, dper_q[6:0]};
         A_SHAPE: rdata = 32'(shape_q);
         A_V2I:   rdata = {16'h0000, v2i_q};
         A_PNOW:  rdata = {16'h0000, per_now_q[14:7], 1'b0, per_now_q[6:0]};
         A_PAVG:  rdata = {16'h0000, per_avg_q[14:7], 1'b0, per_avg_q[6:0]};
         A_IMP:   rdata = {16'h0000, imp_q[9:2], 6'h00, imp_q[1:0]};
         A_STAT:  rdata = {28'h0000000, trk_q, lock_q, brake_q, fault_q};
         default: rdata = 32'h00000000;
      endcase
   end

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmerged[b*8 +: 8] = i_wb_sel[b] ? i_wb_dat[b*8 +: 8] : rdata[b*8 +: 8];
      end
   end

   // Write lands on the edge where the master sees ack
   assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
         o_wb_dat <= rdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_q  <= CTRL_RST;
         gain_q  <= GAIN_RST;
         lim_q   <= LIMIT_RST;
         dper_q  <= DPER_RST;
         shape_q <= SHAPE_RST;
      end else if (wr) begin
         case (i_wb_adr)
            A_CTRL:  ctrl_q  <= hrwc_ctrl_t'(wmerged[8:0]);
            A_GAIN:  gain_q  <= wmerged;
            A_LIMIT: lim_q   <= hrwc_limit_t'(wmerged[23:0]);
            A_DPER:  dper_q  <= {wmerged[15:8], wmerged[6:0]};
            A_SHAPE: shape_q <= hrwc_shape_t'(wmerged[28:0]);
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Zero-cross synchroniser and period timebase
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         zc_sync_q <= 3'h0;
      end else begin
         zc_sync_q <= {zc_sync_q[1:0], i_zero_cross};
      end
   end
   assign zc_evt = zc_sync_q[2] ^ zc_sync_q[1];

   always_ff @(posedge i_clock) begin
      if (i_rst || tick) begin
         tick_q <= 4'h0;
      end else begin
         tick_q <= tick_q + 4'h1;
      end
   end
   assign tick = (tick_q == TICK_LAST);

   // ----------------------------------------------------------------
   // Half-period measurement and period reports
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || zc_evt) begin
         meas_q <= 15'h0000;
      end else if (tick && meas_q != PER_SAT) begin
         meas_q <= meas_q + 15'h0001;
      end
   end

   generate
      for (genvar g = 0; g < 4; g++) begin : g_hist
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               hist_q[g] <= 15'h0000;
            end else if (zc_evt) begin
               hist_q[g] <= (g == 0) ? meas_q : hist_q[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         per_now_q <= 15'h0000;
         per_avg_q <= 15'h0000;
      end else begin
         per_now_q <= 15'(({1'b0, hist_q[0]} + {1'b0, hist_q[1]}));
         per_avg_q <= 15'((({2'b00, hist_q[0]} + {2'b00, hist_q[1]})
                        + ({2'b00, hist_q[2]} + {2'b00, hist_q[3]})) >> 1);
      end
   end

   property p_avg;
      zc_evt |=> ##1 per_avg_q == 15'((({2'b00, hist_q[0]} + {2'b00, hist_q[1]})
                        + ({2'b00, hist_q[2]} + {2'b00, hist_q[3]})) >> 1);
   endproperty
   a_avg: assert property (p_avg) else $error("average period wrong");

   // ----------------------------------------------------------------
   // Resonance PI tracker
   // ----------------------------------------------------------------
   logic signed [16:0] err_c;
   logic [15:0]        kp_c;
   logic signed [33:0] pprod_c;
   logic signed [33:0] iprod_c;
   logic signed [21:0] sum_c;
   logic [16:0]        aerr_c;

   assign trk_ok = ctrl_q.resonance_follow_en & i_play_active
                 & (i_backemf >= lim_q.track_min_backemf);

   always_comb begin
      err_c   = signed'({2'b00, per_now_q}) - signed'({2'b00, track_q});
      aerr_c  = err_c[16] ? 17'(-err_c) : 17'(err_c);
      kp_c    = (ctrl_q.prop_gain_autoscale_en && lock_q)
              ? (gain_q.freq_prop_gain >> 1) : gain_q.freq_prop_gain;
      pprod_c = 34'(err_c) * 34'(signed'({1'b0, kp_c}));
      iprod_c = 34'(err_c) * 34'(signed'({1'b0, gain_q.freq_integ_gain}));
      sum_c   = signed'({7'h00, dper_q}) + 22'(pprod_c >>> GAIN_SHIFT) + integ_q;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst || i_play_start) begin
         integ_q <= 22'sh000000;
         track_q <= dper_q;
         lock_q  <= 1'b0;
      end else if (trk_ok && zc_evt) begin
         integ_q <= integ_q + 22'(iprod_c >>> GAIN_SHIFT);
         if (sum_c < 0) begin
            track_q <= 15'h0000;
         end else if (sum_c > signed'({7'h00, PER_SAT})) begin
            track_q <= PER_SAT;
         end else begin
            track_q <= sum_c[14:0];
         end
         if (aerr_c <= {9'h000, lim_q.initial_lock_threshold}) begin
            lock_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         trk_q <= 1'b0;
      end else begin
         trk_q <= trk_ok;
      end
   end

   property p_trk_off;
      i_backemf < lim_q.track_min_backemf |=> !trk_q;
   endproperty
   a_trk_off: assert property (p_trk_off) else $error("tracking not disabled");

   property p_lock_gate;
      !lock_q |-> kp_c == gain_q.freq_prop_gain;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("gain scaled before lock");

   // ----------------------------------------------------------------
   // Frequency range fault, write one to clear, set wins
   // ----------------------------------------------------------------
   assign range_err = trk_q & ~ctrl_q.range_check_block
                    & ((track_q < PER_MIN) | (track_q > PER_MAX));

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fault_q <= 1'b0;
      end else if (range_err) begin
         fault_q <= 1'b1;
      end else if (wr && i_wb_adr == A_STAT && i_wb_sel[0] && i_wb_dat[0]) begin
         fault_q <= 1'b0;
      end
   end

   property p_range;
      trk_q && !ctrl_q.range_check_block && (track_q < PER_MIN || track_q > PER_MAX)
         |=> fault_q;
   endproperty
   a_range: assert property (p_range) else $error("range fault missing");

   property p_block;
      ctrl_q.range_check_block |-> !range_err;
   endproperty
   a_block: assert property (p_block) else $error("range check not blocked");

   // ----------------------------------------------------------------
   // Half-period drive timing; updates only at zero-cross
   // ----------------------------------------------------------------
   assign bnd = i_play_active & tick & (hp_cnt_q >= {1'b0, act_per_q[14:1]});

   always_ff @(posedge i_clock) begin
      if (i_rst || !i_play_active) begin
         hp_cnt_q  <= 15'h0000;
         act_per_q <= dper_q;
         pol_q     <= 1'b0;
         hp_num_q  <= 3'h0;
         amp_q     <= 8'h00;
      end else if (bnd) begin
         hp_cnt_q <= 15'h0000;
         pol_q    <= ~pol_q;
         if (hp_num_q != 3'h7) begin
            hp_num_q <= hp_num_q + 3'h1;
         end
         if (trk_q) begin
            act_per_q <= track_q;
         end else if (i_frame_per_vld) begin
            act_per_q <= i_frame_per;
         end else begin
            act_per_q <= dper_q;
         end
         if (ctrl_q.amplitude_loop_en && i_backemf > lim_q.brake_threshold) begin
            amp_q <= (i_amplitude > (i_backemf - lim_q.brake_threshold))
                   ? i_amplitude - (i_backemf - lim_q.brake_threshold)
                   : 8'h00;
         end else begin
            amp_q <= i_amplitude;
         end
      end else if (tick) begin
         hp_cnt_q <= hp_cnt_q + 15'h0001;
      end
   end

   property p_zc;
      i_play_active && $changed(amp_q) |-> $past(bnd);
   endproperty
   a_zc: assert property (p_zc) else $error("drive changed off zero-cross");

   property p_amp_loop;
      bnd && ctrl_q.amplitude_loop_en && i_backemf > lim_q.brake_threshold
         |=> amp_q < $past(i_amplitude) || amp_q == 8'h00;
   endproperty
   a_amp_loop: assert property (p_amp_loop) else $error("drive not reduced");

   // ----------------------------------------------------------------
   // Rapid stop braking
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || !i_play_active) begin
         stop_pend_q <= 1'b0;
         brake_q     <= 1'b0;
      end else begin
         if (i_stop_req && ctrl_q.brake_en && hp_num_q > BRAKE_MIN_HP) begin
            stop_pend_q <= 1'b1;
         end else if (bnd) begin
            stop_pend_q <= 1'b0;
         end
         if (brake_q && (zc_evt || i_backemf <= lim_q.brake_threshold)) begin
            brake_q <= 1'b0;
         end else if (bnd && stop_pend_q) begin
            brake_q <= 1'b1;
         end
      end
   end

   property p_brake_min;
      $rose(brake_q) |-> hp_num_q > BRAKE_MIN_HP;
   endproperty
   a_brake_min: assert property (p_brake_min) else $error("brake on short sequence");

   property p_brake_end;
      brake_q && i_backemf <= lim_q.brake_threshold |=> !brake_q;
   endproperty
   a_brake_end: assert property (p_brake_end) else $error("brake not ended");

   // ----------------------------------------------------------------
   // Impedance one-shot and voltage-to-current factor
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         imp_pend_q <= 1'b0;
         imp_q      <= 10'h000;
         v2i_q      <= V2I_RST;
      end else if (i_play_start) begin
         imp_pend_q <= 1'b1;
      end else if (bnd && imp_pend_q) begin
         imp_pend_q <= 1'b0;
         if (!(ctrl_q.factor_hold && ctrl_q.resistance_cal_off)) begin
            imp_q <= i_imp_meas;
            v2i_q <= {6'h00, i_imp_meas};
         end
      end else if (wr && i_wb_adr == A_V2I) begin
         v2i_q <= wmerged[15:0];
      end
   end

   property p_skip;
      bnd && imp_pend_q && ctrl_q.factor_hold && ctrl_q.resistance_cal_off
         |=> $stable(v2i_q) && $stable(imp_q);
   endproperty
   a_skip: assert property (p_skip) else $error("impedance update not skipped");

   // ----------------------------------------------------------------
   // Custom wave: eight points per half, mirrored, sign by polarity
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || !i_play_active || bnd) begin
         step_q <= 15'h0000;
         pt_q   <= 3'h0;
      end else if (tick) begin
         if (step_q >= {4'h0, act_per_q[14:4]}) begin
            step_q <= 15'h0000;
            if (pt_q != 3'h7) begin
               pt_q <= pt_q + 3'h1;
            end
         end else begin
            step_q <= step_q + 15'h0001;
         end
      end
   end

   always_comb begin
      case (pt_q)
         3'h0:    pt_val = PT_ZERO;
         3'h1:    pt_val = {1'b0, shape_q.shape_point1_scale};
         3'h2:    pt_val = {1'b0, shape_q.shape_point2_scale};
         3'h3:    pt_val = {1'b0, shape_q.shape_point3_scale};
         3'h4:    pt_val = PT_PEAK;
         3'h5:    pt_val = {1'b0, shape_q.shape_point3_scale};
         3'h6:    pt_val = {1'b0, shape_q.shape_point2_scale};
         default: pt_val = {1'b0, shape_q.shape_point1_scale};
      endcase
      lvl_prod = 17'(amp_q) * 17'(pt_val);
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_drive_level    <= 8'h00;
         o_drive_polarity <= 1'b0;
         o_brake          <= 1'b0;
         o_fault          <= 1'b0;
         o_track_on       <= 1'b0;
         o_drive_period   <= DPER_RST;
      end else begin
         o_drive_level    <= ctrl_q.shape_gen_select ? lvl_prod[15:8] : amp_q;
         o_drive_polarity <= pol_q ^ brake_q;
         o_brake          <= brake_q;
         o_fault          <= fault_q;
         o_track_on       <= trk_q;
         o_drive_period   <= act_per_q;
      end
   end

   property p_peak;
      ctrl_q.shape_gen_select && pt_q == 3'h4 |=> o_drive_level == $past(amp_q);
   endproperty
   a_peak: assert property (p_peak) else $error("point 4 not at peak");

   property p_polar;
      bnd && !brake_q && !$past(brake_q) && !stop_pend_q
         |=> ##1 o_drive_polarity != $past(o_drive_polarity);
   endproperty
   a_polar: assert property (p_polar) else $error("half-period polarity not flipped");

endmodule : hrwc_top
`default_nettype wire

// ===== verification/hrwc_actuator_model.sv
// Actuator stand-in: back-EMF zero crosses at a fixed half-period
`timescale 1ns/10ps
`default_nettype none
module hrwc_actuator_model #(
   parameter int HALF = 1300
) (
   input  wire logic       i_clock,
   input  wire logic       i_run,
   input  wire logic [7:0] i_level,
   output logic            o_zero_cross,
   output logic      [7:0] o_backemf
);
   int   cnt_q = 0;
   logic zc_q  = 1'b0;
   assign o_zero_cross = zc_q;
   // Comparator pin holds its level while the actuator is at rest
   always_ff @(posedge i_clock) begin
      o_backemf <= i_run ? i_level : 8'h00;
      cnt_q     <= (i_run && cnt_q < HALF - 1) ? cnt_q + 1 : 0;
      if (i_run && cnt_q == HALF - 1) begin
         zc_q <= ~zc_q;
      end
   end
endmodule : hrwc_actuator_model
`default_nettype wire

// ===== verification/hrwc_top_tb.sv
// Self-checking bench of the resonance wave control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
$display("unexpected %s exp %0h got %0h", n, e, g); end end
module hrwc_top_tb;
   import hrwc_pkg::*;
   logic        i_clock, i_rst, cyc, we, ack, zc, start, stop, run, brk, flt, trk, pol;
   logic [7:0]  adr, emf, lvl, dl;
   logic [31:0] wd, rd, q;
   logic [14:0] dp;
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;
   hrwc_top i_hrwc_top (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hF), .o_wb_dat(rd),
      .o_wb_ack(ack), .i_zero_cross(zc), .i_backemf(emf), .i_imp_meas(10'h2D3),
      .i_play_active(run), .i_play_start(start), .i_stop_req(stop), .i_amplitude(8'h80),
      .i_frame_per_vld(1'b0), .i_frame_per(15'h0000), .o_drive_level(dl),
      .o_drive_polarity(pol), .o_brake(brk), .o_fault(flt), .o_track_on(trk),
      .o_drive_period(dp));
   hrwc_actuator_model i_hrwc_actuator_model (.i_clock(i_clock), .i_run(run),
      .i_level(lvl), .o_zero_cross(zc), .o_backemf(emf));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge i_clock); while (ack !== 1'b1);
      q = rd;
      cyc <= 1'b0;
      @(posedge i_clock);
   endtask : wb
   task automatic hp(input int k);
      repeat (k * 1300) @(posedge i_clock);
   endtask : hp
   task automatic play(input int k);
      repeat (4) @(posedge i_clock);
      start <= 1'b1;
      @(posedge i_clock);
      start <= 1'b0;
      run <= 1'b1;
      hp(k);
   endtask : play
   task automatic pulse_stop;
      stop <= 1'b1;
      @(posedge i_clock);
      stop <= 1'b0;
   endtask : pulse_stop
   task automatic wait_brk(input logic v, input int lim);
      int n = 0;
      while (brk !== v && n++ < lim) @(posedge i_clock);
      `CHK("brake", v, brk)
   endtask : wait_brk
   task automatic wait_lvl(input logic [7:0] v, input int lim);
      int n = 0;
      while (dl !== v && n++ < lim) @(posedge i_clock);
      `CHK("drive level", v, dl)
   endtask : wait_lvl
   task automatic t_regs;
      `CHK("drive period", 15'h0EA6, dp)
      wb(0, A_CTRL, 0);
      `CHK("ctrl", 32'h00000181, q)
      wb(0, A_SHAPE, 0);
      `CHK("shape", 32'h1FECB461, q)
      wb(1, 8'h40, 32'h5A5A5A5A);
      wb(0, 8'h40, 0);
      `CHK("unmapped", 32'h00000000, q)
      wb(1, A_GAIN, 32'h00200040);
      wb(0, A_GAIN, 0);
      `CHK("gain", 32'h00200040, q)
      // Half-period of 100 ticks matches the actuator
      wb(1, A_DPER, 32'h00000148);
   endtask : t_regs
   task automatic t_track;
      lvl <= 8'h40;
      play(6);
      `CHK("tracking", 1'b1, trk)
      wb(0, A_PNOW, 0);
      `CHK("period now", 32'h00000148, q)
      wb(0, A_PAVG, 0);
      `CHK("period avg", 32'h00000148, q)
      wb(0, A_IMP, 0);
      `CHK("impedance", 32'h0000B403, q)
      wb(0, A_V2I, 0);
      `CHK("factor", 32'h000002D3, q)
      `CHK("fault", 1'b1, flt)
      wb(1, A_CTRL, 32'h00000185);
      wb(1, A_STAT, 32'h00000001);
      hp(2);
      `CHK("blocked fault", 1'b0, flt)
      lvl <= 8'h08;
      hp(2);
      `CHK("low emf", 1'b0, trk)
      run <= 1'b0;
   endtask : t_track
   task automatic t_brake;
      lvl <= 8'h40;
      play(5);
      pulse_stop();
      wait_brk(1'b1, 2700);
      lvl <= 8'h20;
      wait_brk(1'b0, 100);
      run <= 1'b0;
      play(1);
      pulse_stop();
      hp(3);
      `CHK("short brake", 1'b0, brk)
      run <= 1'b0;
   endtask : t_brake
   task automatic t_amp;
      wb(1, A_V2I, 32'h00001234);
      // Amplitude loop, hold and calibration-off on; tracking and brake off
      wb(1, A_CTRL, 32'h00000038);
      lvl <= 8'h40;
      play(3);
      `CHK("reduced level", 8'h70, dl)
      wb(0, A_V2I, 0);
      `CHK("held factor", 32'h00001234, q)
      run <= 1'b0;
   endtask : t_amp
   task automatic t_shape;
      logic p;
      // Custom wave: select and hold on; tracking, brake, amp loop, sensing off
      wb(1, A_CTRL, 32'h00000048);
      play(2);
      wait_lvl(8'h80, 1400);
      p = pol;
      wait_lvl(8'h00, 1400);
      wait_lvl(8'h80, 1400);
      `CHK("polarity", ~p, pol)
      `CHK("period", 15'h00C8, dp)
      wb(1, A_DPER, 32'h00000150);
      hp(2);
      `CHK("new period", 15'h00D0, dp)
      run <= 1'b0;
   endtask : t_shape
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   initial begin
      {i_rst, cyc, we, start, stop, run} = 6'h20;
      {adr, wd, lvl} = '0;
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      t_regs();
      t_track();
      t_brake();
      t_amp();
      t_shape();
      print_verdict();
   end
   always @(posedge i_clock) begin
      if (++cycles > 80000) begin
         err_total++;
         print_verdict();
      end
   end
endmodule : hrwc_top_tb
`default_nettype wire
